// ---- dv/stc_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module stc_src #(
  parameter integer PERIOD = 40,
  parameter integer HIGH   = 6
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic en_i,
  output var  logic sysref_o
);
  int cnt_r;
  // period kept below the shortest accumulation limit, so every code passes
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r    <= 0;
      sysref_o <= 1'b0;
    end else begin
      cnt_r    <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      sysref_o <= en_i && cnt_r < HIGH;
    end
  end
endmodule // stc_src
`default_nettype wire

// ---- dv/stc_top_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module stc_top_monitor #(
  parameter integer CAL_BOUND_BASE = 4864
) (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        sysref_i,
  input wire logic [16:0] aper_delay_o,
  input wire logic        cal_done_o,
  input wire logic        irq_o
);
  logic        en_r;
  logic [16:0] man_r;
  logic [7:0]  cfg_r;
  logic [1:0]  msk_r;
  int          cnt_r;
  int          bnd_r;
  wire         wr_en = reg_wr_i && reg_addr_i == 12'h2B0;
  // shadows of what software wrote, so outputs can be tied to their cause
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_r  <= 1'b0;
      man_r <= 17'h0_0000;
      cfg_r <= 8'h05;
      msk_r <= 2'h0;
      cnt_r <= 0;
      bnd_r <= 0;
    end else begin
      if (wr_en) en_r <= reg_wdata_i[0];
      if (reg_wr_i && reg_addr_i == 12'h2B1) cfg_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 12'h2B5) man_r[7:0] <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 12'h2B6) man_r[15:8] <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 12'h2B7) man_r[16] <= reg_wdata_i[0];
      if (reg_wr_i && reg_addr_i == 12'h2BA) msk_r <= reg_wdata_i[1:0];
      if (wr_en && reg_wdata_i[0] && !en_r) begin
        cnt_r <= 0;
        bnd_r <= CAL_BOUND_BASE << (2 * (cfg_r[3:2] + cfg_r[1:0] + 2));
      end else begin
        cnt_r <= cnt_r + 1;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  manual_path_a: assert property (
    !en_r && !$past(en_r) |-> aper_delay_o == $past(man_r))
    else $error("delay output is not the manual value");
  result_read_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == 12'h2B2 && cal_done_o
    && $past(cal_done_o) |-> reg_rdata_o == aper_delay_o[7:0])
    else $error("result byte differs from applied delay");
  done_enabled_a: assert property (
    cal_done_o |-> $past(en_r, 2))
    else $error("done seen while disabled");
  no_restart_a: assert property (
    wr_en && reg_wdata_i[0] && en_r && cal_done_o |=> cal_done_o [*2])
    else $error("rewrite of enable restarted calibration");
  done_hold_a: assert property (
    cal_done_o && $past(cal_done_o) && $past(cal_done_o, 2)
    |-> $stable(aper_delay_o))
    else $error("delay moved while done");
  bound_a: assert property (
    $rose(cal_done_o) |-> cnt_r <= bnd_r + 2)
    else $error("calibration took too long");
  cfg_read_a: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == 12'h2B1
    |-> reg_rdata_o == $past(cfg_r))
    else $error("config readback wrong");
  irq_mask_a: assert property (
    msk_r == 2'h0 |-> !irq_o)
    else $error("interrupt while all masked");
  irq_done_a: assert property (
    $rose(cal_done_o) && msk_r[0] |-> irq_o)
    else $error("no interrupt on done");
endmodule // stc_top_monitor
`default_nettype wire

// ---- dv/stc_top_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module stc_top_test;
  localparam integer BASE = 64;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        cal_enable = 1'b1;
  logic        sysref;
  logic [7:0]  reg_rdata_o;
  logic [16:0] aper_delay_o;
  logic        cal_done_o;
  logic        irq_o;
  logic [16:0] exp_d;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n;
  logic [7:0]  cfgs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C,
                            8'h01, 8'h02, 8'h03, 8'h05};
  always #50 clk_i = ~clk_i;
  stc_top #(.CAL_BOUND_BASE(BASE)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sysref_i(sysref),
    .aper_delay_o(aper_delay_o), .cal_done_o(cal_done_o), .irq_o(irq_o));
  stc_src i_src (
    .clk_i(clk_i), .nrst_i(nrst_i), .en_i(cal_enable), .sysref_o(sysref));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, {16'h0, e}, {16'h0, reg_rdata_o});
  endtask
  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // high samples in the window after the edge, scaled to 17 bits
  function automatic logic [16:0] expect_delay(input logic [1:0] hd);
    int c = 0;
    for (int k = 1; k <= (4 << (2 * hd)); k++) c += ((k % 40) < 6);
    return 17'(c << (14 - 2 * hd));
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(12'h2B0, 8'h00, "enable");
    rd(12'h2B1, 8'h05, "config");
    rd(12'h2B7, 8'h00, "manual");
    wr(12'h2B8, 8'h03);
    rd(12'h2B8, 8'h03, "ramp");
    wr(12'h2BF, 8'hFF);
    rd(12'h2BF, 8'h00, "unmapped");
    wr(12'h2B6, 8'h23);
    wr(12'h2B7, 8'hFF);
    rd(12'h2B7, 8'hFF, "manual top");
    wr(12'h2BA, 8'h01);
    foreach (cfgs[i]) begin
      wr(12'h2B1, cfgs[i]);
      wr(12'h2B5, 8'h45);
      // the delay output is registered, one cycle behind the manual byte
      @(posedge clk_i);
      #1 chk("manual delay", 24'h1_2345, {7'h0, aper_delay_o});
      // enable calibration, then wait for done up to the sequence bound
      wr(12'h2B0, 8'h01);
      n = 0;
      while (cal_done_o !== 1'b1 &&
             n <= (BASE << (2 * (cfgs[i][3:2] + cfgs[i][1:0] + 2)))) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      exp_d = expect_delay(cfgs[i][1:0]);
      chk("done", 24'h1, {23'h0, cal_done_o});
      repeat (2) @(posedge clk_i);
      #1 chk("cal delay", {7'h0, exp_d}, {7'h0, aper_delay_o});
      rd(12'h2B2, exp_d[7:0], "result b0");
      rd(12'h2B3, exp_d[15:8], "result b1");
      rd(12'h2B4, {6'h0, 1'b1, exp_d[16]}, "result b2");
      wr(12'h2B2, 8'hFF);
      wr(12'h2B5, 8'hA5);
      wr(12'h2B0, 8'h01);
      rd(12'h2B2, exp_d[7:0], "result kept");
      chk("held delay", {7'h0, exp_d}, {7'h0, aper_delay_o});
      chk("irq", 24'h1, {23'h0, irq_o});
      rd(12'h2B9, 8'h01, "irq status");
      rd(12'h2B9, 8'h00, "irq clear");
      chk("irq low", 24'h0, {23'h0, irq_o});
      wr(12'h2B0, 8'h00);
      repeat (2) @(posedge clk_i);
      #1 chk("back manual", 24'h1_23A5, {7'h0, aper_delay_o});
      chk("done off", 24'h0, {23'h0, cal_done_o});
    end
    cal_enable <= 1'b0;
    wr(12'h2BA, 8'h03);
    wr(12'h2B1, 8'h00);
    wr(12'h2B0, 8'h01);
    // wait limit for duration code 0 is 85 cycles
    repeat (100) @(posedge clk_i);
    #1 chk("fail irq", 24'h1, {23'h0, irq_o});
    chk("fail done", 24'h0, {23'h0, cal_done_o});
    wr(12'h2BA, 8'h00);
    #1 chk("masked irq", 24'h0, {23'h0, irq_o});
    wr(12'h2BA, 8'h03);
    rd(12'h2B9, 8'h02, "fail status");
    chk("fail cleared", 24'h0, {23'h0, irq_o});
    complete_run();
  end
endmodule // stc_top_test
bind stc_top stc_top_monitor #(.CAL_BOUND_BASE(CAL_BOUND_BASE)) i_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sysref_i(sysref_i),
  .aper_delay_o(aper_delay_o), .cal_done_o(cal_done_o), .irq_o(irq_o));
`default_nettype wire

// ---- verilog/stc_accum.v ----
`timescale 1ns/1ns
`default_nettype none
`include "stc_map.vh"

// one high-speed accumulation: waits for a sysref rising edge, then counts
// the high samples of sysref over a window of 4, 16, 64 or 256 cycles
module stc_accum (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       start_i,
  input  wire       abort_i,
  input  wire [1:0] dur_code_i,
  input  wire       sysref_i,
  output reg  [8:0] count_o,
  output reg        done_o,
  output reg        timeout_o
);

  localparam [1:0] A_IDLE = 2'd0;
  localparam [1:0] A_WAIT = 2'd1;
  localparam [1:0] A_CNT  = 2'd2;

  function [14:0] period_max;
    input [1:0] code;
    begin
      case (code)
        2'd0:    period_max = `STC_PERIOD_MAX_0;
        2'd1:    period_max = `STC_PERIOD_MAX_1;
        2'd2:    period_max = `STC_PERIOD_MAX_2;
        default: period_max = `STC_PERIOD_MAX_3;
      endcase
    end
  endfunction

  reg  [1:0]  state_r;
  reg         sysref_d_r;
  reg  [14:0] wait_r;
  reg  [8:0]  win_r;
  reg  [8:0]  high_r;
  wire [8:0]  win_last = (`STC_ACC_LEN_BASE << {dur_code_i, 1'b0}) - 9'h001;
  wire        rise     = sysref_i & ~sysref_d_r;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= A_IDLE;
      sysref_d_r <= 1'b0;
      wait_r     <= 15'h0000;
      win_r      <= 9'h000;
      high_r     <= 9'h000;
      count_o    <= 9'h000;
      done_o     <= 1'b0;
      timeout_o  <= 1'b0;
    end else begin
      sysref_d_r <= sysref_i;
      done_o     <= 1'b0;
      timeout_o  <= 1'b0;
      if (abort_i) begin
        state_r <= A_IDLE;
      end else begin
        case (state_r)
          A_IDLE: begin
            if (start_i) begin
              state_r <= A_WAIT;
              wait_r  <= 15'h0000;
            end
          end
          A_WAIT: begin
            // a sysref period beyond the limit means the measurement fails
            if (rise) begin
              state_r <= A_CNT;
              win_r   <= 9'h000;
              high_r  <= 9'h000;
            end else if (wait_r >= period_max(dur_code_i)) begin
              state_r   <= A_IDLE;
              timeout_o <= 1'b1;
            end else begin
              wait_r <= wait_r + 15'h0001;
            end
          end
          A_CNT: begin
            high_r <= high_r + {8'h00, sysref_i};
            win_r  <= win_r + 9'h001;
            if (win_r == win_last) begin
              count_o <= high_r + {8'h00, sysref_i};
              done_o  <= 1'b1;
              state_r <= A_IDLE;
            end
          end
          default: state_r <= A_IDLE;
        endcase
      end
    end
  end

endmodule // stc_accum
`default_nettype wire

// ---- verilog/stc_map.vh ----
`ifndef STC_MAP_VH
`define STC_MAP_VH

// register offsets (byte addresses on the register port)
`define STC_ADDR_W            12
`define STC_OFF_CAL_ENABLE    12'h2B0
`define STC_OFF_CAL_CONFIG    12'h2B1
`define STC_OFF_RESULT_B0     12'h2B2
`define STC_OFF_RESULT_B1     12'h2B3
`define STC_OFF_RESULT_B2     12'h2B4
`define STC_OFF_MANUAL_B0     12'h2B5
`define STC_OFF_MANUAL_B1     12'h2B6
`define STC_OFF_MANUAL_B2     12'h2B7
`define STC_OFF_RAMP_CTRL     12'h2B8
`define STC_OFF_IRQ_STATUS    12'h2B9
`define STC_OFF_IRQ_MASK      12'h2BA

// field positions
`define STC_EN_BIT            0
`define STC_AVG_MSB           3
`define STC_AVG_LSB           2
`define STC_HDUR_MSB          1
`define STC_HDUR_LSB          0
`define STC_DONE_BIT          17
`define STC_IRQ_DONE_BIT      0
`define STC_IRQ_FAIL_BIT      1

// reset values
`define STC_RST_CAL_ENABLE    8'h00
`define STC_RST_CAL_CONFIG    8'h05
`define STC_RST_MANUAL        24'h000000
`define STC_RST_RAMP_CTRL     8'h00
`define STC_RST_IRQ_MASK      2'h0

// timing counts in sample clock cycles, except STC_AVG_NUM_BASE, a count of averages
`define STC_ACC_LEN_BASE      9'h004
`define STC_AVG_NUM_BASE      9'h004
`define STC_PERIOD_MAX_0      15'd85
`define STC_PERIOD_MAX_1      15'd1100
`define STC_PERIOD_MAX_2      15'd5200
`define STC_PERIOD_MAX_3      15'd21580
`define STC_BOUND_BASE        256 * 19

`endif

// ---- verilog/stc_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "stc_map.vh"

// Overview of operation
// - With calibration disabled the delay output follows the manual delay register bits 16:0, which is the reset state.
// - With calibration enabled the delay output comes from the calibration result and the manual register is ignored.
// - Only a 0-to-1 change of the enable bit starts a calibration; writes leaving it unchanged do not.
// - Bits 3:2 of the configuration select 4, 16, 64 or 256 averages, reset code 1.
// - Bits 1:0 of the configuration select 4, 16, 64 or 256 cycles per accumulation, reset code 1.
// - Calibration ends within 256 x 19 x 4^(averaging code + duration code + 2) cycles.
// - The done bit at status bit 17 reads 1 only while enabled and after the sequence completed.
// - Status bits 16:0 report the computed delay, meaningful only while done reads 1.
module stc_top #(
  parameter integer CAL_BOUND_BASE = `STC_BOUND_BASE
) (
  input  wire                   clk_i,
  input  wire                   nrst_i,
  // register port
  input  wire [`STC_ADDR_W-1:0] reg_addr_i,
  input  wire [7:0]             reg_wdata_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  output reg  [7:0]             reg_rdata_o,
  // sysref from the outside source, sampled on the sample clock
  input  wire                   sysref_i,
  // delay setting applied to the sample clock path
  output reg  [16:0]            aper_delay_o,
  output reg                    cal_done_o,
  output wire                   irq_o
);

  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_RUN  = 2'd1;
  localparam [1:0] S_DONE = 2'd2;
  localparam [1:0] S_FAIL = 2'd3;

  function wr_hit;
    input [`STC_ADDR_W-1:0] off;
    begin
      wr_hit = reg_wr_i && (reg_addr_i == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  reg  [7:0]  cal_enable_r;
  reg  [7:0]  cal_config_r;
  reg  [23:0] manual_delay_r;
  reg  [7:0]  ramp_ctrl_r;
  reg  [1:0]  irq_mask_r;
  reg  [1:0]  irq_stat_r;
  reg  [1:0]  irq_stat_nxt;

  wire        en_bit   = cal_enable_r[`STC_EN_BIT];
  wire        en_wr    = wr_hit(`STC_OFF_CAL_ENABLE);
  wire        en_new   = reg_wdata_i[`STC_EN_BIT];
  wire        cal_start = en_wr && en_new && !en_bit;
  wire        cal_stop  = en_wr && !en_new;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_enable_r   <= `STC_RST_CAL_ENABLE;
      cal_config_r   <= `STC_RST_CAL_CONFIG;
      manual_delay_r <= `STC_RST_MANUAL;
      ramp_ctrl_r    <= `STC_RST_RAMP_CTRL;
      irq_mask_r     <= `STC_RST_IRQ_MASK;
    end else begin
      if (en_wr)
        cal_enable_r <= reg_wdata_i;
      if (wr_hit(`STC_OFF_CAL_CONFIG))
        cal_config_r <= reg_wdata_i;
      if (wr_hit(`STC_OFF_MANUAL_B0))
        manual_delay_r[7:0] <= reg_wdata_i;
      if (wr_hit(`STC_OFF_MANUAL_B1))
        manual_delay_r[15:8] <= reg_wdata_i;
      if (wr_hit(`STC_OFF_MANUAL_B2))
        manual_delay_r[23:16] <= reg_wdata_i;
      if (wr_hit(`STC_OFF_RAMP_CTRL))
        ramp_ctrl_r <= reg_wdata_i;
      if (wr_hit(`STC_OFF_IRQ_MASK))
        irq_mask_r <= reg_wdata_i[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequencer

  reg  [1:0]  state_r;
  reg  [1:0]  avg_code_r;
  reg  [1:0]  dur_code_r;
  reg  [16:0] sum_r;
  reg  [8:0]  avg_cnt_r;
  reg  [31:0] bound_cnt_r;
  reg  [16:0] cal_delay_r;
  reg         acc_start_r;
  reg         ev_done_r;
  reg         ev_fail_r;

  wire [8:0]  acc_count;
  wire        acc_done;
  wire        acc_timeout;

  // the configuration is captured at start, so a late write cannot
  // disturb a sequence already under way
  wire [8:0]  avg_num   = `STC_AVG_NUM_BASE << {avg_code_r, 1'b0};
  wire [2:0]  code_sum  = {1'b0, avg_code_r} + {1'b0, dur_code_r};
  wire [4:0]  bound_sh  = {code_sum, 1'b0} + 5'd4;
  wire [31:0] bound_base = CAL_BOUND_BASE;
  wire [31:0] bound_lim = bound_base << bound_sh;
  wire [3:0]  norm_sh   = 4'd12 - {code_sum, 1'b0};
  wire [16:0] sum_add   = sum_r + {8'h00, acc_count};
  wire        last_avg  = (avg_cnt_r + 9'h001) == avg_num;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r     <= S_IDLE;
      avg_code_r  <= 2'd0;
      dur_code_r  <= 2'd0;
      sum_r       <= 17'h00000;
      avg_cnt_r   <= 9'h000;
      bound_cnt_r <= 32'h00000000;
      cal_delay_r <= 17'h00000;
      acc_start_r <= 1'b0;
      ev_done_r   <= 1'b0;
      ev_fail_r   <= 1'b0;
    end else begin
      acc_start_r <= 1'b0;
      ev_done_r   <= 1'b0;
      ev_fail_r   <= 1'b0;
      if (cal_start) begin
        state_r     <= S_RUN;
        avg_code_r  <= cal_config_r[`STC_AVG_MSB:`STC_AVG_LSB];
        dur_code_r  <= cal_config_r[`STC_HDUR_MSB:`STC_HDUR_LSB];
        sum_r       <= 17'h00000;
        avg_cnt_r   <= 9'h000;
        bound_cnt_r <= 32'h00000000;
        acc_start_r <= 1'b1;
      end else if (cal_stop) begin
        state_r <= S_IDLE;
      end else begin
        case (state_r)
          S_RUN: begin
            bound_cnt_r <= bound_cnt_r + 32'h00000001;
            if (acc_timeout || bound_cnt_r >= bound_lim) begin
              state_r   <= S_FAIL;
              ev_fail_r <= 1'b1;
            end else if (acc_done) begin
              if (last_avg) begin
                cal_delay_r <= sum_add << norm_sh;
                state_r     <= S_DONE;
                ev_done_r   <= 1'b1;
              end else begin
                sum_r       <= sum_add;
                avg_cnt_r   <= avg_cnt_r + 9'h001;
                acc_start_r <= 1'b1;
              end
            end
          end
          S_DONE:  state_r <= S_DONE;
          S_FAIL:  state_r <= S_FAIL;
          S_IDLE:  state_r <= S_IDLE;
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  stc_accum u_accum (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .start_i    (acc_start_r),
    .abort_i    (cal_start || cal_stop),
    .dur_code_i (dur_code_r),
    .sysref_i   (sysref_i),
    .count_o    (acc_count),
    .done_o     (acc_done),
    .timeout_o  (acc_timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // delay output and done flag

  wire done_now = en_bit && (state_r == S_DONE);

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aper_delay_o <= 17'h00000;
      cal_done_o   <= 1'b0;
    end else begin
      cal_done_o <= done_now;
      if (en_bit)
        aper_delay_o <= cal_delay_r;
      else
        aper_delay_o <= manual_delay_r[16:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky events, cleared by reading the status byte

  wire stat_rd = reg_rd_i && (reg_addr_i == `STC_OFF_IRQ_STATUS);

  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (stat_rd)
      irq_stat_nxt = 2'b00;
    // a new event wins over the clear of the same cycle
    irq_stat_nxt[`STC_IRQ_DONE_BIT] = irq_stat_nxt[`STC_IRQ_DONE_BIT]
                                      | ev_done_r;
    irq_stat_nxt[`STC_IRQ_FAIL_BIT] = irq_stat_nxt[`STC_IRQ_FAIL_BIT]
                                      | ev_fail_r;
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      irq_stat_r <= 2'b00;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand only in the cycle after the strobe

  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `STC_OFF_CAL_ENABLE: rdata_nxt = cal_enable_r;
      `STC_OFF_CAL_CONFIG: rdata_nxt = cal_config_r;
      `STC_OFF_RESULT_B0:  rdata_nxt = cal_delay_r[7:0];
      `STC_OFF_RESULT_B1:  rdata_nxt = cal_delay_r[15:8];
      `STC_OFF_RESULT_B2:  rdata_nxt = {6'h00, done_now,
                                        cal_delay_r[16]};
      `STC_OFF_MANUAL_B0:  rdata_nxt = manual_delay_r[7:0];
      `STC_OFF_MANUAL_B1:  rdata_nxt = manual_delay_r[15:8];
      `STC_OFF_MANUAL_B2:  rdata_nxt = manual_delay_r[23:16];
      `STC_OFF_RAMP_CTRL:  rdata_nxt = ramp_ctrl_r;
      `STC_OFF_IRQ_STATUS: rdata_nxt = {6'h00, irq_stat_r};
      `STC_OFF_IRQ_MASK:   rdata_nxt = {6'h00, irq_mask_r};
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_nxt;
    else
      reg_rdata_o <= 8'h00;
  end

endmodule // stc_top
`default_nettype wire
